// *** rtl/wdsc_engine.sv ***
// Watchdog counting engine on count clock ticks, loaded by request and acknowledge
`timescale 1ns/1ps
module wdsc_engine #(
    parameter int SPAN_W = 15
) (
    input wire logic clk_i, // System clock
    input wire logic srst_i, // Power-on reset, synchronous
    input wire logic tick_i, // Count clock edge marker
    input wire logic req_i, // Sync request level
    input wire wdsc_pkg::wdsc_sync_t pkt_i, // Sync word, stable while req_i
    input wire logic [3:0] closed_i, // Closed window code
    input wire logic [3:0] open_i, // Open window or period code
    input wire logic [3:0] warn_i, // Early warning offset code
    output logic ack_o, // Sync acknowledge pulse
    output logic warn_o, // Early warning event pulse
    output logic fault_o, // System reset request, held
    output logic running_o // Counter running
);
    import wdsc_pkg::*;

    typedef enum logic [1:0] {ENG_IDLE, ENG_CLOSED, ENG_OPEN} wdsc_eng_t;

    wdsc_eng_t state_reg;
    logic [SPAN_W-1:0] count_reg;
    logic [SPAN_W-1:0] count_next;
    logic win_reg;
    logic ack_reg;
    logic warn_reg;
    logic fault_reg;
    logic apply;

    generate
        if (SPAN_W < SPAN_W_MIN) begin : g_bad_width
            $error("wdsc_engine: SPAN_W too small for the longest span");
        end
    endgenerate

    // Span length for a code; reserved codes act as the longest span
    function automatic logic [SPAN_W-1:0] span_len(input logic [3:0] code);
        logic [3:0] c;
        c = (code > CODE_MAX) ? CODE_MAX : code;
        span_len = SPAN_W'(1) << (c + 4'(SPAN_BASE_LOG2));
    endfunction

    assign apply = tick_i & req_i & ~ack_reg;
    assign count_next = count_reg + SPAN_W'(1);

    // Acknowledge once per request, on a count edge
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= apply;
        end
    end

    // Phase and counter; a fault stops the engine until power-on reset
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state_reg <= ENG_IDLE;
            count_reg <= '0;
            win_reg <= 1'b0;
            warn_reg <= 1'b0;
            fault_reg <= 1'b0;
        end else begin
            warn_reg <= 1'b0;
            if (fault_reg) begin
                state_reg <= ENG_IDLE;
            end else if (apply) begin
                win_reg <= pkt_i.win;
                count_reg <= '0;
                if (pkt_i.bad_key) begin
                    fault_reg <= 1'b1;
                end else if (pkt_i.kick && state_reg == ENG_CLOSED) begin
                    fault_reg <= 1'b1;
                end else if (pkt_i.kick && state_reg == ENG_IDLE) begin
                    state_reg <= ENG_IDLE;
                end else if (pkt_i.en || pkt_i.lock) begin
                    // Lock keeps the engine running whatever the enable says
                    state_reg <= pkt_i.win ? ENG_CLOSED : ENG_OPEN;
                end else begin
                    state_reg <= ENG_IDLE;
                end
            end else if (tick_i) begin
                case (state_reg)
                    ENG_CLOSED: begin
                        count_reg <= count_next;
                        if (count_next >= span_len(closed_i)) begin
                            state_reg <= ENG_OPEN;
                            count_reg <= '0;
                            warn_reg <= 1'b1;
                        end
                    end
                    ENG_OPEN: begin
                        count_reg <= count_next;
                        if (!win_reg && count_next == span_len(warn_i)) begin
                            warn_reg <= 1'b1;
                        end
                        if (count_next >= span_len(open_i)) begin
                            fault_reg <= 1'b1;
                        end
                    end
                    ENG_IDLE: begin
                        count_reg <= '0;
                    end
                    default: begin
                        state_reg <= ENG_IDLE;
                    end
                endcase
            end
        end
    end

    assign ack_o = ack_reg;
    assign warn_o = warn_reg;
    assign fault_o = fault_reg;
    assign running_o = (state_reg != ENG_IDLE);

endmodule

// *** rtl/wdsc_pkg.sv ***
// Shared constants and types for the watchdog synchronisation and control block
package wdsc_pkg;

    // ------------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------------
    localparam int WDSC_ADDR_W = 4;
    localparam int WDSC_DATA_W = 32;
    localparam int WDSC_LANES = 4;
    localparam int WDSC_BYTE_W = 8;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [3:0] OFF_CONTROL = 4'h0;
    localparam logic [3:0] OFF_TIMING = 4'h1;
    localparam logic [3:0] OFF_WARN = 4'h2;
    localparam logic [3:0] OFF_IRQ_OFF = 4'h4;
    localparam logic [3:0] OFF_IRQ_ON = 4'h5;
    localparam logic [3:0] OFF_PENDING = 4'h6;
    localparam logic [3:0] OFF_STATE = 4'h7;
    localparam logic [3:0] OFF_KEY = 4'h8;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTRL_LOCK_BIT = 7;
    localparam int CTRL_WIN_BIT = 2;
    localparam int CTRL_EN_BIT = 1;
    localparam int CLOSED_LSB = 4;
    localparam int OPEN_LSB = 0;
    localparam int WARN_LSB = 0;
    localparam int CODE_W = 4;
    localparam int FLAG_WARN_BIT = 0;
    localparam int FLAG_SYNC_BIT = 1;
    localparam int FLAG_W = 2;
    localparam int STATE_BUSY_BIT = 7;

    // ------------------------------------------------------------------
    // Values and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RESTART_KEY = 8'ha5;
    localparam logic [3:0] CODE_MAX = 4'hb;
    localparam int SPAN_BASE_LOG2 = 3;
    localparam int SPAN_W_MIN = 15;
    localparam logic [1:0] RST_FLAGS = 2'h0;
    localparam logic [3:0] RST_CODE = 4'h0;

    // Configuration as held in the nonvolatile user row
    typedef struct packed {
        logic lock;
        logic win;
        logic en;
        logic [3:0] closed;
        logic [3:0] open;
        logic [3:0] warn;
    } wdsc_cfg_t;

    // Word carried from the register side to the counting side
    typedef struct packed {
        logic lock;
        logic win;
        logic en;
        logic kick;
        logic bad_key;
    } wdsc_sync_t;

endpackage

// *** rtl/wdsc_top.sv ***
// Register side of the watchdog: bus slave, lock and enable rules, sync handshake
`timescale 1ns/1ps

// Overview of operation
// - Starting a synchronising operation sets sync_in_progress; finishing it clears it.
// - A sync_done_flag in the pending register marks each finished synchronisation.
// - A synchronising write while busy stalls the bus until it can be taken.
// - Control and restart key writes are synchronised; other registers are not.
// - 8, 16 and 32 bit accesses and byte or half parts are accepted.
// - Write-protected registers ignore writes while the write guard is active.
// - Enable-protected fields take writes only while the watchdog is disabled.
// - Writing one sets lock_running; zero does nothing; only power-on reset clears.
// - With lock_running set the watchdog runs regardless of the enable bit.
// - With lock_running set, control and setup registers ignore writes but window_select.
// - Control bits 6 to 3 and bit 0 always read zero.
// - window_select takes writes only when enable is zero or lock_running is one.
// - window_select zero means normal mode, one means window mode.
// - Enable is writable only while lock_running is zero; one enables.
// - Written enable reads back at once; the effect follows the synchronisation.
// - Lock, window and enable bits load from the nonvolatile row at startup.
// - closed_span_code gives 8 cycles doubling to 16384; codes above 0xB reserved.
// - Both span codes load from the nonvolatile row at startup.
// - open_span_code sets the period, or the open window in window mode.
// - Key 0xA5 restarts the period; any other value forces a system reset.
// - A restart inside the closed window forces a system reset.
// - In normal mode an expired period forces a system reset.
module wdsc_top #(
    parameter int SPAN_W = 15
) (
    input wire logic clk_i, // System clock, 125 MHz
    input wire logic srst_i, // Power-on reset, synchronous
    input wire logic bus_req_i, // Access request
    input wire logic bus_we_i, // 1 write, 0 read
    input wire logic [wdsc_pkg::WDSC_ADDR_W-1:0] bus_addr_i, // Byte address
    input wire logic [wdsc_pkg::WDSC_LANES-1:0] bus_be_i, // Byte enables
    input wire logic [wdsc_pkg::WDSC_DATA_W-1:0] bus_wdata_i, // Write data
    output logic bus_ready_o, // Access taken this cycle
    output logic bus_rvalid_o, // Read data valid pulse
    output logic [wdsc_pkg::WDSC_DATA_W-1:0] bus_rdata_o, // Read data
    input wire logic count_tick_i, // Count clock edge marker
    input wire logic write_guard_i, // Write guard protection active
    input wire wdsc_pkg::wdsc_cfg_t nvm_cfg_i, // User row configuration
    output logic irq_o, // Interrupt request
    output logic sys_reset_o, // System reset request, held
    output logic running_o // Watchdog counter running
);
    import wdsc_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic lock_reg;
    logic win_reg;
    logic en_reg;
    logic [3:0] closed_reg;
    logic [3:0] open_reg;
    logic [3:0] warn_code_reg;
    logic [FLAG_W-1:0] irq_en_reg;
    logic [FLAG_W-1:0] flags_reg;
    logic [FLAG_W-1:0] flags_next;
    logic busy_reg;
    logic req_reg;
    wdsc_sync_t pkt_reg;
    logic load_reg;
    logic [WDSC_DATA_W-1:0] rdata_reg;
    logic rvalid_reg;
    logic [WDSC_DATA_W-1:0] rword;
    logic take;
    logic wr;
    logic rd;
    logic w_ctrl;
    logic w_timing;
    logic w_warn;
    logic w_irq_off;
    logic w_irq_on;
    logic w_pending;
    logic w_key;
    logic sync_touch;
    logic sync_start;
    logic [7:0] d_ctrl;
    logic [7:0] d_key;
    logic ack;
    logic warn_evt;

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------

    // Byte lane of a register is hit when its word is addressed and its lane enabled
    function automatic logic lane_hit(input logic [WDSC_ADDR_W-1:0] addr,
                                      input logic [WDSC_LANES-1:0] be,
                                      input logic [3:0] off);
        lane_hit = (addr[WDSC_ADDR_W-1:2] == off[3:2]) && be[off[1:0]];
    endfunction

    // Data byte for a register offset within the bus word
    function automatic logic [7:0] lane_byte(input logic [WDSC_DATA_W-1:0] data,
                                             input logic [3:0] off);
        lane_byte = data[off[1:0]*WDSC_BYTE_W +: WDSC_BYTE_W];
    endfunction

    // ------------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------------

    // Besides the startup load cycle, only a write that must cross to the counting side can stall; reads stall only during that load
    assign sync_touch = bus_we_i && (lane_hit(bus_addr_i, bus_be_i, OFF_CONTROL)
                        || (lane_hit(bus_addr_i, bus_be_i, OFF_KEY) && !write_guard_i));
    // Held off while the user row loads, so nothing races the startup values
    assign bus_ready_o = !load_reg && !(sync_touch && busy_reg);
    assign take = bus_req_i && bus_ready_o;
    assign wr = take && bus_we_i;
    assign rd = take && !bus_we_i;

    // Per-register write strobes
    assign w_ctrl = wr && lane_hit(bus_addr_i, bus_be_i, OFF_CONTROL);
    assign w_timing = wr && lane_hit(bus_addr_i, bus_be_i, OFF_TIMING);
    assign w_warn = wr && lane_hit(bus_addr_i, bus_be_i, OFF_WARN);
    assign w_irq_off = wr && lane_hit(bus_addr_i, bus_be_i, OFF_IRQ_OFF);
    assign w_irq_on = wr && lane_hit(bus_addr_i, bus_be_i, OFF_IRQ_ON);
    assign w_pending = wr && lane_hit(bus_addr_i, bus_be_i, OFF_PENDING);
    assign w_key = wr && lane_hit(bus_addr_i, bus_be_i, OFF_KEY) && !write_guard_i;
    assign d_ctrl = lane_byte(bus_wdata_i, OFF_CONTROL);
    assign d_key = lane_byte(bus_wdata_i, OFF_KEY);

    // Control and key writes both start a crossing; they sit in different words
    assign sync_start = w_ctrl || w_key;

    // ------------------------------------------------------------------
    // Startup load
    // ------------------------------------------------------------------

    // One cycle after reset release the user row is copied in and pushed across
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            load_reg <= 1'b1;
        end else begin
            load_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------

    // Lock is sticky: writes of zero and every write after it is set are ignored
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            lock_reg <= 1'b0;
        end else if (load_reg) begin
            lock_reg <= nvm_cfg_i.lock;
        end else if (w_ctrl && d_ctrl[CTRL_LOCK_BIT]) begin
            lock_reg <= 1'b1;
        end
    end

    // Enable reads back as written, before the counting side has acted on it
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            en_reg <= 1'b0;
        end else if (load_reg) begin
            en_reg <= nvm_cfg_i.en;
        end else if (w_ctrl && !lock_reg) begin
            en_reg <= d_ctrl[CTRL_EN_BIT];
        end
    end

    // Window select is enable-protected unless locked; locked it stays writable
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            win_reg <= 1'b0;
        end else if (load_reg) begin
            win_reg <= nvm_cfg_i.win;
        end else if (w_ctrl && (!en_reg || lock_reg)) begin
            win_reg <= d_ctrl[CTRL_WIN_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Timing and early warning setup
    // ------------------------------------------------------------------

    // Span codes are read live by the engine, so no crossing is needed here
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            closed_reg <= RST_CODE;
            open_reg <= RST_CODE;
        end else if (load_reg) begin
            closed_reg <= nvm_cfg_i.closed;
            open_reg <= nvm_cfg_i.open;
        end else if (w_timing && !lock_reg) begin
            closed_reg <= CODE_W'(lane_byte(bus_wdata_i, OFF_TIMING) >> CLOSED_LSB);
            open_reg <= CODE_W'(lane_byte(bus_wdata_i, OFF_TIMING) >> OPEN_LSB);
        end
    end

    // Early warning offset is write-protected and frozen by the lock
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            warn_code_reg <= RST_CODE;
        end else if (load_reg) begin
            warn_code_reg <= nvm_cfg_i.warn;
        end else if (w_warn && !lock_reg && !write_guard_i) begin
            warn_code_reg <= CODE_W'(lane_byte(bus_wdata_i, OFF_WARN) >> WARN_LSB);
        end
    end

    // ------------------------------------------------------------------
    // Interrupt enables and pending flags
    // ------------------------------------------------------------------

    // Set and clear views of one enable; clear wins if both hit in one access
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            irq_en_reg <= RST_FLAGS;
        end else if (!write_guard_i) begin
            if (w_irq_on) begin
                irq_en_reg <= irq_en_reg | FLAG_W'(lane_byte(bus_wdata_i, OFF_IRQ_ON));
            end
            if (w_irq_off) begin
                irq_en_reg <= (irq_en_reg
                    | (w_irq_on ? FLAG_W'(lane_byte(bus_wdata_i, OFF_IRQ_ON)) : RST_FLAGS))
                    & ~FLAG_W'(lane_byte(bus_wdata_i, OFF_IRQ_OFF));
            end
        end
    end

    // A new event beats a software clear in the same cycle, so none is lost
    always_comb begin
        flags_next = flags_reg;
        if (w_pending) begin
            flags_next = flags_next & ~FLAG_W'(lane_byte(bus_wdata_i, OFF_PENDING));
        end
        if (warn_evt) begin
            flags_next[FLAG_WARN_BIT] = 1'b1;
        end
        if (ack) begin
            flags_next[FLAG_SYNC_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            flags_reg <= RST_FLAGS;
        end else begin
            flags_reg <= flags_next;
        end
    end

    assign irq_o = |(flags_reg & irq_en_reg);

    // ------------------------------------------------------------------
    // Crossing to the counting side
    // ------------------------------------------------------------------

    // Busy rises with the accepted write and falls with the acknowledge
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            busy_reg <= 1'b0;
            req_reg <= 1'b0;
        end else if (load_reg || sync_start) begin
            busy_reg <= 1'b1;
            req_reg <= 1'b1;
        end else if (ack) begin
            busy_reg <= 1'b0;
            req_reg <= 1'b0;
        end
    end

    // Word stays stable for the whole request; a stalled write cannot disturb it
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pkt_reg <= '0;
        end else if (load_reg) begin
            pkt_reg <= '{lock: nvm_cfg_i.lock, win: nvm_cfg_i.win, en: nvm_cfg_i.en,
                         kick: 1'b0, bad_key: 1'b0};
        end else if (w_ctrl) begin
            pkt_reg.lock <= lock_reg | d_ctrl[CTRL_LOCK_BIT];
            pkt_reg.win <= (!en_reg || lock_reg) ? d_ctrl[CTRL_WIN_BIT] : win_reg;
            pkt_reg.en <= lock_reg ? en_reg : d_ctrl[CTRL_EN_BIT];
            pkt_reg.kick <= 1'b0;
            pkt_reg.bad_key <= 1'b0;
        end else if (w_key) begin
            pkt_reg.kick <= (d_key == RESTART_KEY);
            pkt_reg.bad_key <= (d_key != RESTART_KEY);
        end
    end

    wdsc_engine #(
        .SPAN_W(SPAN_W)
    ) u_engine (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .tick_i(count_tick_i),
        .req_i(req_reg),
        .pkt_i(pkt_reg),
        .closed_i(closed_reg),
        .open_i(open_reg),
        .warn_i(warn_code_reg),
        .ack_o(ack),
        .warn_o(warn_evt),
        .fault_o(sys_reset_o),
        .running_o(running_o)
    );

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------

    // Unmapped words and the key register read zero; reserved bits read zero
    always_comb begin
        rword = '0;
        case (bus_addr_i[WDSC_ADDR_W-1:2])
            OFF_CONTROL[3:2]: begin
                rword[OFF_CONTROL[1:0]*WDSC_BYTE_W +: WDSC_BYTE_W] =
                    {lock_reg, 4'h0, win_reg, en_reg, 1'b0};
                rword[OFF_TIMING[1:0]*WDSC_BYTE_W +: WDSC_BYTE_W] = {closed_reg, open_reg};
                rword[OFF_WARN[1:0]*WDSC_BYTE_W +: WDSC_BYTE_W] = {4'h0, warn_code_reg};
            end
            OFF_IRQ_OFF[3:2]: begin
                rword[OFF_IRQ_OFF[1:0]*WDSC_BYTE_W +: WDSC_BYTE_W] = {6'h00, irq_en_reg};
                rword[OFF_IRQ_ON[1:0]*WDSC_BYTE_W +: WDSC_BYTE_W] = {6'h00, irq_en_reg};
                rword[OFF_PENDING[1:0]*WDSC_BYTE_W +: WDSC_BYTE_W] = {6'h00, flags_reg};
                rword[OFF_STATE[1:0]*WDSC_BYTE_W + STATE_BUSY_BIT] = busy_reg;
            end
            default: begin
                rword = '0;
            end
        endcase
    end

    // Data is registered and lanes not enabled are masked to zero
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rdata_reg <= '0;
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= rd;
            if (rd) begin
                for (int i = 0; i < WDSC_LANES; i++) begin
                    rdata_reg[i*WDSC_BYTE_W +: WDSC_BYTE_W] <=
                        bus_be_i[i] ? rword[i*WDSC_BYTE_W +: WDSC_BYTE_W] : 8'h00;
                end
            end
        end
    end

    assign bus_rdata_o = rdata_reg;
    assign bus_rvalid_o = rvalid_reg;

endmodule

// *** testbench/wdsc_assertions.sv ***
// Port checker for the watchdog register side
`timescale 1ns/1ps
module wdsc_assertions
    import wdsc_pkg::*;
(
    input wire logic clk_i, // System clock
    input wire logic srst_i, // Power-on reset
    input wire logic bus_req_i, // Access request
    input wire logic bus_we_i, // Write select
    input wire logic [WDSC_ADDR_W-1:0] bus_addr_i, // Byte address
    input wire logic [WDSC_LANES-1:0] bus_be_i, // Byte enables
    input wire logic [WDSC_DATA_W-1:0] bus_wdata_i, // Write data
    input wire logic bus_ready_o, // Access taken
    input wire logic bus_rvalid_o, // Read data valid
    input wire logic [WDSC_DATA_W-1:0] bus_rdata_o, // Read data
    input wire logic write_guard_i, // Write guard
    input wire wdsc_cfg_t nvm_cfg_i, // User row values
    input wire logic sys_reset_o, // System reset
    input wire logic running_o // Counter running
);
    logic rd_t;
    logic bad_key;
    // Taken read, and a taken unguarded restart write with a wrong key
    assign rd_t = bus_req_i && bus_ready_o && !bus_we_i;
    assign bad_key = bus_req_i && bus_ready_o && bus_we_i && bus_addr_i[3:2] == 2'h2
        && bus_be_i[0] && !write_guard_i && bus_wdata_i[7:0] != RESTART_KEY;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    AST_RD_ANS: assert property (rd_t |=> bus_rvalid_o)
        else $error("read not answered");
    AST_RD_ONLY: assert property (!rd_t |=> !bus_rvalid_o)
        else $error("stray read valid");
    AST_RD_NOSTALL: assert property (bus_req_i && !bus_we_i && !$past(srst_i) |-> bus_ready_o)
        else $error("read stalled");
    AST_STALL_END: assert property (bus_req_i && !bus_ready_o |-> ##[1:40] bus_ready_o)
        else $error("stall never ends");
    AST_KEY_BAD: assert property (bad_key |-> ##[1:24] sys_reset_o)
        else $error("wrong key gave no reset");
    AST_SYS_HOLD: assert property (sys_reset_o |=> sys_reset_o)
        else $error("system reset dropped");
    AST_CTRL_RSV: assert property (rd_t && bus_addr_i[3:2] == 2'h0 |=>
        bus_rdata_o[6:3] == 4'h0 && !bus_rdata_o[0])
        else $error("reserved control bits set");
    AST_LANE_OFF: assert property (rd_t && !bus_be_i[3] |=> bus_rdata_o[31:24] == 8'h00)
        else $error("disabled lane not zero");
    AST_LOCK_RUN: assert property ($fell(srst_i) && nvm_cfg_i.lock |-> ##[1:24] running_o)
        else $error("locked watchdog not running");
    // Main scenarios reached
    cover property (bus_req_i && !bus_ready_o);
    cover property (bad_key);
    cover property ($rose(sys_reset_o));
endmodule

// *** testbench/wdsc_core_model.sv ***
// Core model: register bus master that holds each request until it is taken
`timescale 1ns/1ps
module wdsc_core_model (
    input wire logic clk_i, // System clock
    input wire logic ready_i, // Access taken
    input wire logic [31:0] rdata_i, // Read data
    output logic req_o = 1'b0, // Request
    output logic we_o = 1'b0, // Write select
    output logic [3:0] addr_o = 4'h0, // Byte address
    output logic [3:0] be_o = 4'h0, // Byte enables
    output logic [31:0] wdata_o = 32'h0 // Write data
);
    logic ok;
    // Hold the whole request until ready is seen high at a falling edge
    task automatic xfer(input logic w, input logic [3:0] a, b, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge clk_i);
        {req_o, we_o, addr_o, be_o, wdata_o} <= {1'b1, w, a, b, d};
        do begin
            @(negedge clk_i);
            ok = ready_i;
            @(posedge clk_i);
        end while (!ok);
        // Released lines show the inverse so no stale value can pass
        {req_o, we_o, addr_o, be_o, wdata_o} <= {1'b0, ~w, ~a, ~b, ~d};
        @(negedge clk_i);
        @(negedge clk_i);
        q = rdata_i;
    endtask
endmodule

// *** testbench/wdsc_tb_top.sv ***
// Top bench: drives the watchdog register side through the core model
`timescale 1ns/1ps
module wdsc_tb_top;
    import wdsc_pkg::*;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic count_tick_i = 1'b0;
    logic write_guard_i = 1'b0;
    logic tick_on = 1'b1;
    wdsc_cfg_t nvm_cfg_i = '0;
    logic bus_req_i, bus_we_i, bus_ready_o, bus_rvalid_o, irq_o, sys_reset_o, running_o;
    logic [3:0] bus_addr_i, bus_be_i;
    logic [31:0] bus_wdata_i, bus_rdata_o, q;
    int bad_count = 0, n_compared = 0, cyc = 0;
    always #4 clk_i = ~clk_i;
    wdsc_top wdsc_top_inst (.*);
    wdsc_core_model wdsc_core_model_inst (.clk_i(clk_i), .ready_i(bus_ready_o),
        .rdata_i(bus_rdata_o), .req_o(bus_req_i), .we_o(bus_we_i), .addr_o(bus_addr_i),
        .be_o(bus_be_i), .wdata_o(bus_wdata_i));
    // Count clock marker every eighth cycle; can be frozen to hold a sync open
    always @(posedge clk_i) begin
        count_tick_i <= tick_on && cyc[2:0] == 3'h0;
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish;
        if (bad_count == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, b, input logic [31:0] d);
        wdsc_core_model_inst.xfer(1'b1, a, b, d, q);
    endtask
    task automatic rd(input logic [3:0] a, b);
        wdsc_core_model_inst.xfer(1'b0, a, b, 32'h0, q);
    endtask
    // Reset for ten cycles with a given user row
    task automatic boot(input wdsc_cfg_t c);
        @(posedge clk_i);
        srst_i <= 1'b1;
        nvm_cfg_i <= c;
        repeat (10) @(posedge clk_i);
        srst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask
    // Poll until no synchronisation is pending; the timeout bounds it
    task automatic settle;
        do rd(4'h4, 4'h8); while (q[31] !== 1'b0);
    endtask
    task automatic sys_after(input int n, input logic e);
        repeat (n) @(negedge clk_i);
        chk({7'h0, sys_reset_o}, {7'h0, e});
    endtask
    initial begin
        logic [7:0] r;
        void'($urandom(32'h3bd5aed4));
        boot({1'b0, 1'b1, 1'b0, 4'h2, 4'h0, 4'h1});
        rd(4'h0, 4'h3);
        chk(q[7:0], 8'h04);
        chk(q[15:8], 8'h20);
        settle();
        tick_on <= 1'b0;
        wr(4'h0, 4'h1, 32'h7f);
        rd(4'h4, 4'h8);
        chk({7'h0, q[31]}, 8'h01);
        rd(4'h0, 4'h1);
        chk(q[7:0], 8'h06);
        tick_on <= 1'b1;
        settle();
        rd(4'h4, 4'h4);
        chk({7'h0, q[17]}, 8'h01);
        wr(4'h4, 4'h2, 32'h0200);
        chk({7'h0, irq_o}, 8'h01);
        wr(4'h0, 4'h1, 32'h02);
        rd(4'h0, 4'h1);
        chk(q[7:0], 8'h06);
        @(posedge clk_i) write_guard_i <= 1'b1;
        wr(4'h0, 4'h4, 32'h000b0000);
        rd(4'h0, 4'h4);
        chk(q[23:16], 8'h01);
        @(posedge clk_i) write_guard_i <= 1'b0;
        wr(4'h8, 4'h1, 32'ha5);
        sys_after(40, 1'b1);
        boot({1'b1, 1'b0, 1'b0, 4'h0, 4'h1, 4'h0});
        settle();
        wr(4'h0, 4'h1, 32'h04);
        wr(4'h0, 4'h2, 32'h0000ff00);
        rd(4'h0, 4'h3);
        chk(q[7:0], 8'h84);
        chk(q[15:8], 8'h01);
        chk({7'h0, running_o}, 8'h01);
        boot('0);
        settle();
        r = {4'($urandom % 12), 4'($urandom % 12)};
        wr(4'h0, 4'h3, {16'h0, r, 8'h00});
        rd(4'h0, 4'h2);
        chk(q[15:8], r);
        wr(4'h0, 4'h3, 32'h0002);
        settle();
        sys_after(24, 1'b0);
        sys_after(80, 1'b1);
        boot('0);
        settle();
        @(posedge clk_i) write_guard_i <= 1'b1;
        wr(4'h8, 4'h1, 32'h5a);
        sys_after(40, 1'b0);
        @(posedge clk_i) write_guard_i <= 1'b0;
        wr(4'h8, 4'h1, 32'h5a);
        sys_after(30, 1'b1);
        tally_and_finish();
    end
endmodule
bind wdsc_top wdsc_assertions wdsc_assertions_inst (.*);
